// File: shared/bcs_pkg.sv
// constants, opcode set and shared helpers for the flow-control unit
// assumes the fetch stage hands over pre-decoded operations
package bcs_pkg;

  // ----------------------------------------
  // decoded operations
  // ----------------------------------------
  typedef enum logic [4:0] {
    op_none                = 5'h00,
    register_compare       = 5'h01,
    compare_with_carry     = 5'h02,
    compare_immediate      = 5'h03,
    compare_skip_equal     = 5'h04,
    skip_reg_bit_clear     = 5'h05,
    skip_reg_bit_set       = 5'h06,
    skip_io_bit_clear      = 5'h07,
    skip_io_bit_set        = 5'h08,
    branch_flag_set        = 5'h09,
    branch_flag_clear      = 5'h0A,
    branch_equal           = 5'h0B,
    branch_not_equal       = 5'h0C,
    branch_carry_set       = 5'h0D,
    branch_carry_clear     = 5'h0E,
    branch_same_or_higher  = 5'h0F,
    branch_lower           = 5'h10,
    branch_minus           = 5'h11,
    branch_plus            = 5'h12,
    branch_signed_ge       = 5'h13,
    branch_signed_lt       = 5'h14,
    branch_halfcarry_set   = 5'h15,
    branch_halfcarry_clear = 5'h16,
    branch_transfer_set    = 5'h17,
    branch_transfer_clear  = 5'h18,
    branch_overflow_set    = 5'h19
  } op_t;

  // ----------------------------------------
  // status_register bit positions
  // ----------------------------------------
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;

  // ----------------------------------------
  // program counter steps and reset values
  // ----------------------------------------
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [15:0] PC_SKIP_ONE = 16'h0002;
  localparam logic [15:0] PC_SKIP_TWO = 16'h0003;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // ----------------------------------------
  // operation classes
  // ----------------------------------------
  function automatic logic is_compare(input op_t op);
    return op inside {register_compare, compare_with_carry,
                      compare_immediate};
  endfunction

  function automatic logic is_skip(input op_t op);
    return op inside {compare_skip_equal, skip_reg_bit_clear,
                      skip_reg_bit_set, skip_io_bit_clear,
                      skip_io_bit_set};
  endfunction

  function automatic logic is_branch(input op_t op);
    return (op >= branch_flag_set) && (op <= branch_overflow_set);
  endfunction

  // signed word displacement widened to the pc width
  function automatic logic [15:0] disp_ext(input logic [6:0] k);
    return {{9{k[6]}}, k};
  endfunction

endpackage

// File: shared/unit_link_if.sv
// operands and results passed between the unit and its two helpers
// assumes all three ends run on the same core clock
`timescale 1ns/1ps
interface unit_link_if;
  bcs_pkg::op_t op;       // operation being decided
  logic [2:0] sel;        // bit or flag selector
  logic [7:0] imm;        // immediate operand
  logic [7:0] rd_val;     // first register operand
  logic [7:0] rr_val;     // second register operand
  logic [7:0] status;     // current status_register
  logic io_bit;           // addressed i/o bit value
  logic take;             // skip or branch condition holds
  logic [7:0] flags_new;  // status after a compare

  modport core(output op, sel, imm, rd_val, rr_val, status, io_bit,
               input take, flags_new);
  modport cond(input op, sel, rd_val, rr_val, status, io_bit,
               output take);
  modport alu(input op, imm, rd_val, rr_val, status,
              output flags_new);
endinterface

// File: rtl/compare_alu.sv
// subtract-only flag generator for the compare operations
// assumes operands are stable for the cycle the op is offered
`timescale 1ns/1ps
module compare_alu (
  unit_link_if.alu lnk
);

  logic [7:0] sub_b;     // subtrahend
  logic borrow_in;       // carry term for the carry form
  logic [8:0] diff;      // difference with borrow out
  logic [7:0] res;       // low byte of difference

  // ----------------------------------------
  // difference and flags, result is dropped
  // ----------------------------------------
  always_comb begin
    sub_b = (lnk.op == bcs_pkg::compare_immediate) ?
            lnk.imm : lnk.rr_val;
    borrow_in = (lnk.op == bcs_pkg::compare_with_carry) ?
                lnk.status[bcs_pkg::FLAG_C] : 1'b0;
    diff = {1'b0, lnk.rd_val} - {1'b0, sub_b} - {8'h00, borrow_in};
    res = diff[7:0];
    // other flags pass through untouched
    lnk.flags_new = lnk.status;
    lnk.flags_new[bcs_pkg::FLAG_Z] = (res == 8'h00);
    lnk.flags_new[bcs_pkg::FLAG_N] = res[7];
    lnk.flags_new[bcs_pkg::FLAG_C] = diff[8];
    // overflow when signs of operands differ and result flips
    lnk.flags_new[bcs_pkg::FLAG_V] =
      (lnk.rd_val[7] & ~sub_b[7] & ~res[7]) |
      (~lnk.rd_val[7] & sub_b[7] & res[7]);
    // borrow out of the low nibble
    lnk.flags_new[bcs_pkg::FLAG_H] =
      (~lnk.rd_val[3] & sub_b[3]) | (sub_b[3] & res[3]) |
      (res[3] & ~lnk.rd_val[3]);
  end

endmodule

// File: rtl/branch_cond_eval.sv
// condition evaluator for skips and relative branches
// assumes status_register is the committed value of this cycle
`timescale 1ns/1ps
module branch_cond_eval (
  unit_link_if.cond lnk
);

  logic c_f, z_f, n_f, v_f, h_f, t_f; // flag shorthands

  // ----------------------------------------
  // condition per operation
  // ----------------------------------------
  always_comb begin
    c_f = lnk.status[bcs_pkg::FLAG_C];
    z_f = lnk.status[bcs_pkg::FLAG_Z];
    n_f = lnk.status[bcs_pkg::FLAG_N];
    v_f = lnk.status[bcs_pkg::FLAG_V];
    h_f = lnk.status[bcs_pkg::FLAG_H];
    t_f = lnk.status[bcs_pkg::FLAG_T];
    unique case (lnk.op)
      bcs_pkg::compare_skip_equal:
        lnk.take = (lnk.rd_val == lnk.rr_val);
      bcs_pkg::skip_reg_bit_clear:
        lnk.take = ~lnk.rr_val[lnk.sel];
      bcs_pkg::skip_reg_bit_set:
        lnk.take = lnk.rr_val[lnk.sel];
      bcs_pkg::skip_io_bit_clear:
        lnk.take = ~lnk.io_bit;
      bcs_pkg::skip_io_bit_set:
        lnk.take = lnk.io_bit;
      bcs_pkg::branch_flag_set:
        lnk.take = lnk.status[lnk.sel];
      bcs_pkg::branch_flag_clear:
        lnk.take = ~lnk.status[lnk.sel];
      bcs_pkg::branch_equal: lnk.take = z_f;
      bcs_pkg::branch_not_equal: lnk.take = ~z_f;
      bcs_pkg::branch_carry_set,
      bcs_pkg::branch_lower: lnk.take = c_f;
      bcs_pkg::branch_carry_clear,
      bcs_pkg::branch_same_or_higher: lnk.take = ~c_f;
      bcs_pkg::branch_minus: lnk.take = n_f;
      bcs_pkg::branch_plus: lnk.take = ~n_f;
      bcs_pkg::branch_signed_ge: lnk.take = ~(n_f ^ v_f);
      bcs_pkg::branch_signed_lt: lnk.take = n_f ^ v_f;
      bcs_pkg::branch_halfcarry_set: lnk.take = h_f;
      bcs_pkg::branch_halfcarry_clear: lnk.take = ~h_f;
      bcs_pkg::branch_transfer_set: lnk.take = t_f;
      bcs_pkg::branch_transfer_clear: lnk.take = ~t_f;
      bcs_pkg::branch_overflow_set: lnk.take = v_f;
      // compares, idle and unused codes never redirect
      default: lnk.take = 1'b0;
    endcase
  end

endmodule

// File: rtl/branch_compare_skip_unit.sv
// conditional flow unit: compares, skips and relative branches
// assumes fetch presents one decoded op per cycle and holds it
// while busy is high; pc is the address of the offered op
//
// What this block does
// - equal registers skip next, flags kept
// - compares set Z N V C H only
// - register bit zero skips next instruction
// - register bit one skips next instruction
// - i/o bit zero skips next instruction
// - i/o bit one skips next instruction
// - selected flag set branches to pc+k+1
// - selected flag clear branches relative
// - zero flag picks equal and not-equal
// - carry set or lower branches on C
// - carry clear or same-higher on C zero
// - minus and plus follow negative flag
// - signed ge branches when N xor V zero
// - signed lt branches when N xor V one
// - half-carry branches set and clear
// - transfer flag branches set and clear
// - overflow set branches to pc+k+1
`timescale 1ns/1ps
module branch_compare_skip_unit (
  input wire logic clk,
  input wire logic srst,
  input wire logic op_valid,
  input wire bcs_pkg::op_t op,
  input wire logic [2:0] sel,
  input wire logic [6:0] disp,
  input wire logic [7:0] imm,
  input wire logic [15:0] pc,
  input wire logic next_two_word,
  input wire logic [7:0] rd_val,
  input wire logic [7:0] rr_val,
  input wire logic io_bit_val,
  input wire logic [7:0] status_register,
  output logic busy,
  output logic pc_load,
  output logic [15:0] pc_target,
  output logic flags_we,
  output logic [7:0] flags_out
);

  // ----------------------------------------
  // sequencing states
  // ----------------------------------------
  typedef enum logic [1:0] {
    st_idle = 2'h0,      // ready for an op
    st_drop_one = 2'h1,  // discarding one fetched word
    st_drop_two = 2'h2   // discarding a two-word op
  } state_t;

  state_t state_reg;     // current state
  state_t state_next;    // next state
  logic busy_reg;        // op input refused
  logic pc_load_reg;     // redirect pulse
  logic [15:0] pc_target_reg; // redirect address
  logic [15:0] pc_target_next;
  logic flags_we_reg;    // status write pulse
  logic [7:0] flags_out_reg; // status to write
  logic accept;          // op taken this cycle
  logic redirect;        // skip or branch taken

  unit_link_if lnk();    // operands to the helpers

  // ----------------------------------------
  // helper wiring
  // ----------------------------------------
  assign lnk.op = op;
  assign lnk.sel = sel;
  assign lnk.imm = imm;
  assign lnk.rd_val = rd_val;
  assign lnk.rr_val = rr_val;
  assign lnk.status = status_register;
  assign lnk.io_bit = io_bit_val;

  compare_alu u_alu (
    .lnk(lnk.alu)
  );

  branch_cond_eval u_cond (
    .lnk(lnk.cond)
  );

  // ----------------------------------------
  // acceptance and redirect decision
  // ----------------------------------------
  // ops offered while busy are ignored; fetch must hold them
  assign accept = op_valid && (state_reg == st_idle);
  assign redirect = accept && lnk.take &&
                    (bcs_pkg::is_skip(op) || bcs_pkg::is_branch(op));

  // ----------------------------------------
  // next state: how many fetched words to drop
  // ----------------------------------------
  always_comb begin
    state_next = st_idle;
    unique case (state_reg)
      st_idle: begin
        if (redirect && bcs_pkg::is_skip(op) && next_two_word) begin
          state_next = st_drop_two; // three cycles
        end else if (redirect) begin
          state_next = st_drop_one; // two cycles
        end
      end
      st_drop_two: state_next = st_drop_one;
      st_drop_one: state_next = st_idle;
      // unused code: recover to idle
      default: state_next = st_idle;
    endcase
  end

  // ----------------------------------------
  // target address
  // ----------------------------------------
  always_comb begin
    if (bcs_pkg::is_skip(op)) begin
      // step over the following one- or two-word op
      pc_target_next = next_two_word ?
        pc + bcs_pkg::PC_SKIP_TWO : pc + bcs_pkg::PC_SKIP_ONE;
    end else begin
      // sign-extended word offset plus one
      pc_target_next = pc + bcs_pkg::disp_ext(disp) + bcs_pkg::PC_STEP;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= st_idle;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // busy: fetched word is squashed meanwhile
  // ----------------------------------------
  // a discarded op never reaches execute, so it changes nothing
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= (state_next != st_idle);
    end
  end

  // ----------------------------------------
  // program counter redirect
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      pc_load_reg <= 1'b0;
      pc_target_reg <= bcs_pkg::PC_RESET;
    end else begin
      pc_load_reg <= redirect;
      if (redirect) begin
        pc_target_reg <= pc_target_next;
      end
    end
  end

  // ----------------------------------------
  // status write for compares only
  // ----------------------------------------
  // skips and branches never raise the write strobe, so flags hold
  always_ff @(posedge clk) begin
    if (srst) begin
      flags_we_reg <= 1'b0;
      flags_out_reg <= bcs_pkg::FLAGS_RESET;
    end else begin
      flags_we_reg <= accept && bcs_pkg::is_compare(op);
      if (accept && bcs_pkg::is_compare(op)) begin
        flags_out_reg <= lnk.flags_new;
      end
    end
  end

  assign busy = busy_reg;
  assign pc_load = pc_load_reg;
  assign pc_target = pc_target_reg;
  assign flags_we = flags_we_reg;
  assign flags_out = flags_out_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  chk_skip_eq_jump: assert property (
    accept && op == bcs_pkg::compare_skip_equal &&
    rd_val == rr_val && !next_two_word
    |=> pc_load && pc_target == $past(pc) + 16'h0002 && !flags_we)
    else $error("equal skip did not step by two");

  chk_compare_flags: assert property (
    accept && bcs_pkg::is_compare(op)
    |=> flags_we && !busy && !pc_load &&
        flags_out[bcs_pkg::FLAG_Z] == ($past(rd_val) == $past(rr_val) &&
        $past(op) == bcs_pkg::register_compare ||
        $past(op) != bcs_pkg::register_compare &&
        flags_out[bcs_pkg::FLAG_Z]))
    else $error("compare flag write wrong");

  chk_reg_bit_clear: assert property (
    accept && op == bcs_pkg::skip_reg_bit_clear && !rr_val[sel]
    |=> pc_load)
    else $error("register bit clear skip missed");

  chk_reg_bit_set: assert property (
    accept && op == bcs_pkg::skip_reg_bit_set && !rr_val[sel]
    |=> !pc_load && !busy)
    else $error("register bit set skip taken wrongly");

  chk_io_bit_clear: assert property (
    accept && op == bcs_pkg::skip_io_bit_clear && io_bit_val
    |=> !pc_load)
    else $error("io bit clear skip taken wrongly");

  chk_io_two_word: assert property (
    accept && op == bcs_pkg::skip_io_bit_set && io_bit_val &&
    next_two_word
    |=> pc_load && busy ##1 busy && !pc_load ##1 !busy)
    else $error("two-word skip did not last three cycles");

  chk_branch_target: assert property (
    accept && op == bcs_pkg::branch_flag_set && status_register[sel]
    |=> pc_load &&
        pc_target == $past(pc) + {{9{$past(disp[6])}}, $past(disp)} + 16'h0001)
    else $error("branch target wrong");

  chk_branch_not_taken: assert property (
    accept && op == bcs_pkg::branch_lower &&
    !status_register[bcs_pkg::FLAG_C]
    |=> !pc_load && !busy && !flags_we)
    else $error("untaken branch stalled or redirected");

  chk_taken_two_cycles: assert property (
    accept && bcs_pkg::is_branch(op) && lnk.take
    |=> busy ##1 !busy)
    else $error("taken branch not exactly two cycles");

  chk_signed_lt: assert property (
    accept && op == bcs_pkg::branch_signed_lt &&
    (status_register[bcs_pkg::FLAG_N] ^ status_register[bcs_pkg::FLAG_V])
    |=> pc_load)
    else $error("signed less-than branch missed");

  chk_flag_clear_taken: assert property (
    accept && op == bcs_pkg::branch_flag_clear && !status_register[sel]
    |=> pc_load && busy && !flags_we)
    else $error("flag clear branch missed");

  chk_not_equal_zero: assert property (
    accept && op == bcs_pkg::branch_not_equal &&
    status_register[bcs_pkg::FLAG_Z]
    |=> !pc_load && !busy)
    else $error("not-equal branch taken on zero");

  chk_same_or_higher: assert property (
    accept && op == bcs_pkg::branch_same_or_higher &&
    !status_register[bcs_pkg::FLAG_C]
    |=> pc_load && busy)
    else $error("same-or-higher branch missed");

  chk_minus_clear: assert property (
    accept && op == bcs_pkg::branch_minus &&
    !status_register[bcs_pkg::FLAG_N]
    |=> !pc_load)
    else $error("minus branch taken on clear N");

  chk_signed_ge: assert property (
    accept && op == bcs_pkg::branch_signed_ge &&
    (status_register[bcs_pkg::FLAG_N] ^ status_register[bcs_pkg::FLAG_V])
    |=> !pc_load && !busy)
    else $error("signed ge branch taken wrongly");

  chk_overflow_target: assert property (
    accept && op == bcs_pkg::branch_overflow_set &&
    status_register[bcs_pkg::FLAG_V]
    |=> pc_load &&
        pc_target == $past(pc) + {{9{$past(disp[6])}}, $past(disp)} + 16'h0001)
    else $error("overflow branch target wrong");

  chk_skip_one_word: assert property (
    accept && bcs_pkg::is_skip(op) && lnk.take && !next_two_word
    |=> pc_load && busy ##1 !busy && !pc_load)
    else $error("one-word skip not two cycles");

  // a second pulse would make fetch reload a stale target
  chk_pulse_single: assert property (
    pc_load |=> !pc_load)
    else $error("redirect pulse longer than one cycle");

  chk_busy_no_write: assert property (
    busy |=> !flags_we && !pc_load)
    else $error("op taken while busy");

  cov_branch_taken: cover property (
    accept && bcs_pkg::is_branch(op) && lnk.take);
  cov_skip_two_word: cover property (
    accept && bcs_pkg::is_skip(op) && lnk.take && next_two_word);
  cov_compare: cover property (accept && bcs_pkg::is_compare(op));
  cov_refused_offer: cover property (busy && op_valid);
  cov_skip_one_word: cover property (
    accept && bcs_pkg::is_skip(op) && lnk.take && !next_two_word);

endmodule

// File: verification/branch_compare_skip_unit_tb_top.sv
// self-checking bench for the conditional flow unit
// assumes the unit's top module and bcs_pkg are compiled before this file
`timescale 1ns/1ps
module branch_compare_skip_unit_tb_top;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0; // 100 MHz core clock
  logic srst = 1'b1; // held high for the first six cycles
  logic op_valid = 1'b0;
  bcs_pkg::op_t op = bcs_pkg::op_none;
  logic [2:0] sel = 3'h0;
  logic [6:0] disp = 7'h00;
  logic [7:0] imm = 8'h00;
  logic [15:0] pc = 16'h0000;
  logic next_two_word = 1'b0;
  logic [7:0] rd_val = 8'h00;
  logic [7:0] rr_val = 8'h00;
  logic io_bit_val = 1'b0;
  logic [7:0] status_register = 8'h00;
  logic busy, pc_load, flags_we;
  logic [15:0] pc_target;
  logic [7:0] flags_out;
  int errors = 0;
  int checks = 0;
  logic [7:0] last_flags = 8'h00; // flags_out must hold this
  logic [15:0] last_target = 16'h0000; // pc_target must hold this
  logic [7:0] st_tab [7] = '{8'h00, 8'hFF, 8'h05, 8'h0A, 8'h28, 8'h48, 8'h0C};

  branch_compare_skip_unit DUT (.clk(clk), .srst(srst), .op_valid(op_valid),
    .op(op), .sel(sel), .disp(disp), .imm(imm), .pc(pc),
    .next_two_word(next_two_word), .rd_val(rd_val), .rr_val(rr_val),
    .io_bit_val(io_bit_val), .status_register(status_register),
    .busy(busy), .pc_load(pc_load), .pc_target(pc_target),
    .flags_we(flags_we), .flags_out(flags_out));

  // free-running clock
  always begin
    #5 clk = ~clk;
  end

  // ----------------------------------------
  // reporting
  // ----------------------------------------
  // one comparison; case inequality so an unknown never matches
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string msg);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h",
               $time, msg, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // reference model
  // ----------------------------------------
  // flags after a - b - cin; S and unrelated bits copied from st
  function automatic logic [7:0] cmp_flags(input logic [7:0] a,
      input logic [7:0] b, input logic cin, input logic [7:0] st);
    logic [7:0] r;
    logic [7:0] f;
    r = a - b - {7'h00, cin};
    f = st;
    f[bcs_pkg::FLAG_Z] = (r == 8'h00);
    f[bcs_pkg::FLAG_N] = r[7];
    f[bcs_pkg::FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    f[bcs_pkg::FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    f[bcs_pkg::FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    return f;
  endfunction

  // skip or branch condition, written out per operation
  function automatic logic cond(input bcs_pkg::op_t o, input logic [2:0] s,
      input logic [7:0] a, input logic [7:0] b, input logic io,
      input logic [7:0] st);
    logic n_x_v;
    n_x_v = st[bcs_pkg::FLAG_N] ^ st[bcs_pkg::FLAG_V];
    case (o)
      bcs_pkg::compare_skip_equal: return a == b;
      bcs_pkg::skip_reg_bit_clear: return ~b[s];
      bcs_pkg::skip_reg_bit_set: return b[s];
      bcs_pkg::skip_io_bit_clear: return ~io;
      bcs_pkg::skip_io_bit_set: return io;
      bcs_pkg::branch_flag_set: return st[s];
      bcs_pkg::branch_flag_clear: return ~st[s];
      bcs_pkg::branch_equal: return st[bcs_pkg::FLAG_Z];
      bcs_pkg::branch_not_equal: return ~st[bcs_pkg::FLAG_Z];
      bcs_pkg::branch_carry_set: return st[bcs_pkg::FLAG_C];
      bcs_pkg::branch_lower: return st[bcs_pkg::FLAG_C];
      bcs_pkg::branch_carry_clear: return ~st[bcs_pkg::FLAG_C];
      bcs_pkg::branch_same_or_higher: return ~st[bcs_pkg::FLAG_C];
      bcs_pkg::branch_minus: return st[bcs_pkg::FLAG_N];
      bcs_pkg::branch_plus: return ~st[bcs_pkg::FLAG_N];
      bcs_pkg::branch_signed_ge: return ~n_x_v;
      bcs_pkg::branch_signed_lt: return n_x_v;
      bcs_pkg::branch_halfcarry_set: return st[bcs_pkg::FLAG_H];
      bcs_pkg::branch_halfcarry_clear: return ~st[bcs_pkg::FLAG_H];
      bcs_pkg::branch_transfer_set: return st[bcs_pkg::FLAG_T];
      bcs_pkg::branch_transfer_clear: return ~st[bcs_pkg::FLAG_T];
      bcs_pkg::branch_overflow_set: return st[bcs_pkg::FLAG_V];
      default: return 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // shared driver: offer one op, judge every cycle until idle
  // ----------------------------------------
  // entered just after an edge; returns just after checking the answer
  // when nothing is taken, so ops go back to back
  task automatic run_op(input bcs_pkg::op_t o, input logic [2:0] s,
      input logic [6:0] k, input logic [7:0] a, input logic [7:0] b,
      input logic io, input logic [7:0] st, input logic ntw);
    logic cmp, skp, tk, cin;
    int hold;
    cmp = o inside {bcs_pkg::register_compare, bcs_pkg::compare_with_carry,
                    bcs_pkg::compare_immediate};
    skp = o inside {bcs_pkg::compare_skip_equal, bcs_pkg::skip_reg_bit_clear,
                    bcs_pkg::skip_reg_bit_set, bcs_pkg::skip_io_bit_clear,
                    bcs_pkg::skip_io_bit_set};
    tk = cond(o, s, a, b, io, st);
    cin = (o == bcs_pkg::compare_with_carry) ? st[bcs_pkg::FLAG_C] : 1'b0;
    hold = (skp && ntw) ? 2 : 1;
    if (cmp) begin
      last_flags = cmp_flags(a, b, cin, st);
    end
    if (tk && skp) begin
      last_target = pc + (ntw ? 16'h0003 : 16'h0002);
    end else if (tk) begin
      last_target = pc + {{9{k[6]}}, k} + 16'h0001;
    end
    op = o;
    sel = s;
    disp = k;
    rd_val = a;
    // immediate form must ignore rr_val
    rr_val = (o == bcs_pkg::compare_immediate) ? ~b : b;
    imm = b;
    io_bit_val = io;
    status_register = st;
    next_two_word = ntw;
    op_valid = 1'b1;
    @(posedge clk);
    #1;
    op_valid = 1'b0;
    op = bcs_pkg::op_none;
    check(pc_load, tk, "pc_load");
    check(busy, tk, "busy after take");
    check(flags_we, cmp, "flags_we");
    check(pc_target, last_target, "pc_target");
    check(flags_out, last_flags, "flags_out");
    for (int i = 1; i <= (tk ? hold : 0); i++) begin
      @(posedge clk);
      #1;
      check(pc_load, 1'b0, "pc_load pulse");
      check(busy, (i < hold), "busy length");
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // zero, borrow, signed overflow, carry in and S copy
  task automatic test_compares();
    run_op(bcs_pkg::register_compare, 3'h0, 7'h00, 8'h10, 8'h10, 1'b0,
           8'h10, 1'b0);
    run_op(bcs_pkg::register_compare, 3'h0, 7'h00, 8'h00, 8'h01, 1'b0,
           8'h02, 1'b0);
    run_op(bcs_pkg::compare_with_carry, 3'h0, 7'h00, 8'h80, 8'h00, 1'b0,
           8'h01, 1'b0);
    run_op(bcs_pkg::compare_with_carry, 3'h0, 7'h00, 8'h05, 8'h05, 1'b0,
           8'h01, 1'b0);
    run_op(bcs_pkg::compare_with_carry, 3'h0, 7'h00, 8'h05, 8'h05, 1'b0,
           8'hFC, 1'b0);
    run_op(bcs_pkg::compare_immediate, 3'h0, 7'h00, 8'h7F, 8'hFF, 1'b0,
           8'h00, 1'b0);
    run_op(bcs_pkg::compare_immediate, 3'h0, 7'h00, 8'h3C, 8'h3C, 1'b0,
           8'h00, 1'b0);
  endtask

  // every skip, both outcomes, one- and two-word shadow; skip_reg_bit_set is taken only over a one-word shadow
  task automatic test_skips();
    logic [7:0] dv [3] = '{8'h00, 8'hFF, 8'h5A};
    pc = 16'hFFFE;
    for (int i = 4; i <= 8; i++) begin
      for (int j = 0; j < 6; j++) begin
        run_op(bcs_pkg::op_t'(i[4:0]), 3'(j), 7'h00, 8'h5A, dv[j % 3],
               j[0], 8'hFF, j[1]);
      end
    end
  endtask

  // every branch over a spread of status values and displacements
  task automatic test_branches();
    for (int i = 9; i <= 25; i++) begin
      for (int j = 0; j < 7; j++) begin
        pc = j[0] ? 16'h0010 : 16'hFFF0; // both wrap directions
        run_op(bcs_pkg::op_t'(i[4:0]), 3'(j),
               j[0] ? 7'h40 : 7'h3F, 8'h00,
               8'h00, 1'b0, st_tab[j],
               1'b0);
      end
    end
  endtask

  // a compare offered during a two-word skip must be dropped
  task automatic test_refuse();
    run_op(bcs_pkg::skip_io_bit_set, 3'h0, 7'h00, 8'h00, 8'h00, 1'b1,
           8'h00, 1'b0);
    op = bcs_pkg::skip_io_bit_set;
    io_bit_val = 1'b1;
    next_two_word = 1'b1;
    op_valid = 1'b1;
    @(posedge clk);
    #1;
    op = bcs_pkg::register_compare;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      #1;
      op_valid = (i == 0);
      check(flags_we, 1'b0, "op taken while busy");
    end
  endtask

  // reset in mid-operation clears the pulses and the target
  task automatic test_reset_mid();
    pc = 16'h1234;
    run_op(bcs_pkg::branch_equal, 3'h0, 7'h01, 8'h00, 8'h00, 1'b0,
           8'h02, 1'b0);
    op = bcs_pkg::branch_equal;
    op_valid = 1'b1;
    @(posedge clk);
    #1;
    op_valid = 1'b0;
    srst = 1'b1;
    @(posedge clk);
    #1;
    srst = 1'b0;
    check(busy, 1'b0, "busy after reset");
    check(pc_load, 1'b0, "pc_load after reset");
    check(pc_target, bcs_pkg::PC_RESET, "pc_target after reset");
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    #1;
    check(busy, 1'b0, "busy in reset");
    check(pc_load, 1'b0, "pc_load in reset");
    check(flags_we, 1'b0, "flags_we in reset");
    check(flags_out, bcs_pkg::FLAGS_RESET, "flags_out in reset");
    srst = 1'b0;
    test_compares();
    test_skips();
    test_branches();
    test_refuse();
    test_reset_mid();
    end_sim();
  end

  // the whole run needs well under 2000 cycles
  initial begin
    #200000;
    errors++;
    end_sim();
  end
endmodule
